/* servo_homing.sv */
// Functional notes
// - velocity is command position change per cycle
// - armed sensor edge sets done, holds position
// - armed z-phase edge holds position and sets done in the same cycle
// - position set holds new position, sets done
// - single-turn unsigned, multi-turn signed, ccw up
// - overflow alarm only when setup enables it
// - position is multi-turn shifted plus single-turn
// - only low 32 bits are reported
// - homing acceptance clears done flag
// - normal command aborts homing even busy
module servo_homing (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cycle_tick,
  input wire logic [19:0] single_turn,
  input wire logic [15:0] multi_turn,
  input wire logic multi_turn_overflow,
  input wire logic z_phase,
  input wire logic external_input_one,
  input wire logic torque_limited,
  output logic [31:0] servo_target,
  output logic [31:0] command_velocity,
  output logic [31:0] composed_actual_position,
  output logic homing_done,
  output logic homing_busy,
  output logic overflow_alarm
);

  logic [31:0] cmd_q;
  logic [31:0] cmd_pos_q;
  logic [31:0] setting_q;
  logic [31:0] config_q;
  logic [31:0] prev_pos_q;
  logic [31:0] vel_q;
  logic [31:0] offset_q;
  logic [31:0] hold_q;
  logic [31:0] hold_d;
  logic [31:0] target_q;
  logic [31:0] composed_actual_position_q;
  logic [7:0] echo_q;
  logic [7:0] prev_code_q;
  logic done_q;
  logic done_d;
  logic ovf_q;
  logic ovf_d;
  logic external_input_one_prev_q;
  logic z_prev_q;
  logic [31:0] rdata_q;
  logic pready_q;
  servo_homing_pkg::home_state_t state_q;
  servo_homing_pkg::home_state_t state_d;

  // bus decode
  logic access;
  logic ack;
  logic wr_ack;
  logic hit_cmd;
  logic hit_pos;
  logic hit_set;
  logic hit_cfg;
  logic hit_sts;
  logic hit_vel;
  logic hit_composed_actual_position;
  logic hit_tgt;
  logic hit_echo;
  logic addr_ok;
  logic [31:0] wmask;
  logic [31:0] cmd_wval;
  logic [31:0] pos_wval;
  logic [31:0] set_wval;
  logic [31:0] cfg_wval;
  logic ovf_clear;
  logic [31:0] rd_mux;
  logic [31:0] status_val;

  // command and config fields
  logic [7:0] cmd_code;
  logic arm;
  logic [11:0] type_code;
  logic dir_ccw;
  logic ovf_en;
  logic enc20;

  // position composition
  logic [servo_homing_pkg::comp_w-1:0] mt_ext;
  logic [servo_homing_pkg::comp_w-1:0] st17_ext;
  logic [servo_homing_pkg::comp_w-1:0] st20_ext;
  logic [servo_homing_pkg::comp_w-1:0] raw17;
  logic [servo_homing_pkg::comp_w-1:0] raw20;
  logic [servo_homing_pkg::comp_w-1:0] raw_sel;
  logic [servo_homing_pkg::comp_w-1:0] neg_sel;
  logic [servo_homing_pkg::comp_w-1:0] signed_sel;
  logic [31:0] raw_pos;
  logic [32:0] composed_actual_position_sum;
  logic [32:0] set_diff;
  logic [32:0] vel_diff;

  // homing control
  logic code_is_homing;
  logic homing_start;
  logic homing_leave;
  logic z_rise;
  logic external_input_one_rise;
  logic trig_z;
  logic trig_ext;
  logic trig_set;
  logic trigger;
  logic accept;
  logic lock_enter;
  logic [31:0] hold_src;

  assign access = psel && penable;
  assign ack = access && pready_q;
  assign wr_ack = ack && pwrite;
  assign hit_cmd = paddr == servo_homing_pkg::cmd_off;
  assign hit_pos = paddr == servo_homing_pkg::cmd_pos_off;
  assign hit_set = paddr == servo_homing_pkg::setting_off;
  assign hit_cfg = paddr == servo_homing_pkg::config_off;
  assign hit_sts = paddr == servo_homing_pkg::status_off;
  assign hit_vel = paddr == servo_homing_pkg::cmd_vel_off;
  assign hit_composed_actual_position = paddr == servo_homing_pkg::act_pos_off;
  assign hit_tgt = paddr == servo_homing_pkg::target_off;
  assign hit_echo = paddr == servo_homing_pkg::echo_off;
  assign addr_ok = hit_cmd || hit_pos || hit_set || hit_cfg || hit_sts || hit_vel ||
                   hit_composed_actual_position || hit_tgt || hit_echo;

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{pstrb[b]}};
  end

  assign cmd_wval = (cmd_q & ~wmask) | (pwdata & wmask);
  assign pos_wval = (cmd_pos_q & ~wmask) | (pwdata & wmask);
  assign set_wval = (setting_q & ~wmask) | (pwdata & wmask);
  assign cfg_wval = (config_q & ~wmask) | (pwdata & wmask);
  assign ovf_clear = wr_ack && hit_sts && pwdata[servo_homing_pkg::ovf_bit] && pstrb[0];

  assign pready = pready_q;
  assign prdata = rdata_q;
  // unknown offsets answer with an error but still complete, so a host never hangs
  assign pslverr = ack && !addr_ok;

  assign cmd_code = cmd_q[servo_homing_pkg::cmd_code_lsb +: 8];
  assign arm = cmd_q[servo_homing_pkg::arm_bit];
  assign type_code = cmd_q[servo_homing_pkg::type_code_lsb +: 12];
  assign dir_ccw = config_q[servo_homing_pkg::dir_bit];
  assign ovf_en = config_q[servo_homing_pkg::ovf_en_bit];
  assign enc20 = config_q[servo_homing_pkg::enc20_bit];

  // multi-turn is signed, single-turn unsigned; 17-bit mode ignores the top inputs
  assign mt_ext = {{20{multi_turn[15]}}, multi_turn};
  assign st17_ext = {19'h0_0000, single_turn[16:0]};
  assign st20_ext = {16'h0000, single_turn};
  assign raw17 = (mt_ext << servo_homing_pkg::st17_w) + st17_ext;
  assign raw20 = (mt_ext << servo_homing_pkg::st20_w) + st20_ext;
  assign raw_sel = enc20 ? raw20 : raw17;
  // negate on the full width first, so the truncated word keeps its two's complement
  assign neg_sel = ~raw_sel + 36'h0_0000_0001;
  assign signed_sel = dir_ccw ? raw_sel : neg_sel;
  assign raw_pos = signed_sel[31:0];
  assign composed_actual_position_sum = {1'b0, raw_pos} + {1'b0, offset_q};
  assign set_diff = {1'b0, setting_q} - {1'b0, raw_pos};
  assign vel_diff = {1'b0, cmd_pos_q} - {1'b0, prev_pos_q};

  assign code_is_homing = cmd_code == servo_homing_pkg::code_homing;
  assign homing_start = cycle_tick && code_is_homing &&
                        (prev_code_q != servo_homing_pkg::code_homing);
  assign homing_leave = cycle_tick && !code_is_homing;
  assign z_rise = z_phase && !z_prev_q;
  assign external_input_one_rise = external_input_one && !external_input_one_prev_q;
  assign trig_z = arm && (type_code == servo_homing_pkg::type_z_rise) && z_rise;
  assign trig_ext = arm && (type_code == servo_homing_pkg::type_external_input_one_rise) && external_input_one_rise;
  // the position set needs no sensor and ignores the arm bit
  assign trig_set = type_code == servo_homing_pkg::type_composed_actual_position_set;
  assign trigger = trig_z || trig_ext || trig_set;
  assign accept = (state_q == servo_homing_pkg::hs_idle) && homing_start;
  assign lock_enter = (state_q == servo_homing_pkg::hs_seek) && cycle_tick &&
                      code_is_homing && trigger;
  assign hold_src = trig_set ? setting_q : composed_actual_position_q;
  assign hold_d = lock_enter ? hold_src : hold_q;

  assign homing_busy = state_q == servo_homing_pkg::hs_seek;
  assign homing_done = done_q;
  assign overflow_alarm = ovf_q;
  assign servo_target = target_q;
  assign command_velocity = vel_q;
  assign composed_actual_position = composed_actual_position_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      servo_homing_pkg::hs_idle: begin
        if (homing_start) begin
          state_d = servo_homing_pkg::hs_seek;
        end
      end
      servo_homing_pkg::hs_seek: begin
        if (homing_leave) begin
          state_d = servo_homing_pkg::hs_idle;
        end else if (lock_enter) begin
          state_d = servo_homing_pkg::hs_lock;
        end
      end
      servo_homing_pkg::hs_lock: begin
        if (homing_leave) begin
          state_d = servo_homing_pkg::hs_idle;
        end
      end
      default: begin
        state_d = servo_homing_pkg::hs_idle;
      end
    endcase
  end

  always_comb begin
    done_d = done_q;
    if (accept) begin
      done_d = 1'b0;
    end
    if (lock_enter) begin
      done_d = 1'b1;
    end
  end

  // a new overflow wins over a clear in the same cycle
  assign ovf_d = (multi_turn_overflow && ovf_en) || (ovf_q && !ovf_clear);

  always_comb begin
    status_val = 32'h0000_0000;
    status_val[servo_homing_pkg::done_bit] = done_q;
    status_val[servo_homing_pkg::tlim_bit] = torque_limited;
    status_val[servo_homing_pkg::external_input_one_bit] = external_input_one;
    status_val[servo_homing_pkg::busy_bit] = state_q == servo_homing_pkg::hs_seek;
    status_val[servo_homing_pkg::ovf_bit] = ovf_q;
    status_val[servo_homing_pkg::locked_bit] = state_q == servo_homing_pkg::hs_lock;
  end

  always_comb begin
    case (paddr)
      servo_homing_pkg::cmd_off: rd_mux = cmd_q;
      servo_homing_pkg::cmd_pos_off: rd_mux = cmd_pos_q;
      servo_homing_pkg::setting_off: rd_mux = setting_q;
      servo_homing_pkg::config_off: rd_mux = config_q;
      servo_homing_pkg::status_off: rd_mux = status_val;
      servo_homing_pkg::cmd_vel_off: rd_mux = vel_q;
      servo_homing_pkg::act_pos_off: rd_mux = composed_actual_position_q;
      servo_homing_pkg::target_off: rd_mux = target_q;
      servo_homing_pkg::echo_off: rd_mux = {24'h00_0000, echo_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state: read data is captured in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= access && !pready_q;
      if (access && !pready_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= servo_homing_pkg::cmd_rst;
      cmd_pos_q <= 32'h0000_0000;
      setting_q <= 32'h0000_0000;
      config_q <= servo_homing_pkg::config_rst;
    end else if (wr_ack) begin
      if (hit_cmd) begin
        cmd_q <= cmd_wval;
      end
      if (hit_pos) begin
        cmd_pos_q <= pos_wval;
      end
      if (hit_set) begin
        setting_q <= set_wval;
      end
      if (hit_cfg) begin
        config_q <= cfg_wval;
      end
    end
  end

  // command sampling follows the communication cycle, not the bus clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_code_q <= servo_homing_pkg::code_normal;
      echo_q <= 8'h00;
      z_prev_q <= 1'b0;
      external_input_one_prev_q <= 1'b0;
      prev_pos_q <= 32'h0000_0000;
      vel_q <= 32'h0000_0000;
    end else if (cycle_tick) begin
      prev_code_q <= cmd_code;
      echo_q <= cmd_code;
      z_prev_q <= z_phase;
      external_input_one_prev_q <= external_input_one;
      prev_pos_q <= cmd_pos_q;
      vel_q <= vel_diff[31:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= servo_homing_pkg::hs_idle;
      done_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q <= done_d;
      ovf_q <= ovf_d;
    end
  end

  // while locked the command position is ignored and the hold value drives the loop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 32'h0000_0000;
      target_q <= 32'h0000_0000;
    end else begin
      hold_q <= hold_d;
      target_q <= (state_d == servo_homing_pkg::hs_lock) ? hold_d : cmd_pos_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_q <= 32'h0000_0000;
      composed_actual_position_q <= 32'h0000_0000;
    end else begin
      if (lock_enter && trig_set) begin
        offset_q <= set_diff[31:0];
      end
      composed_actual_position_q <= composed_actual_position_sum[31:0];
    end
  end

endmodule

/* servo_homing_pkg.sv */
package servo_homing_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] cmd_off = 8'h00;
  localparam logic [7:0] cmd_pos_off = 8'h04;
  localparam logic [7:0] setting_off = 8'h08;
  localparam logic [7:0] config_off = 8'h0C;
  localparam logic [7:0] status_off = 8'h10;
  localparam logic [7:0] cmd_vel_off = 8'h14;
  localparam logic [7:0] act_pos_off = 8'h18;
  localparam logic [7:0] target_off = 8'h1C;
  localparam logic [7:0] echo_off = 8'h20;

  // command register fields
  localparam int cmd_code_lsb = 0;
  localparam int arm_bit = 8;
  localparam int type_code_lsb = 16;

  // config register fields
  localparam int dir_bit = 0;
  localparam int ovf_en_bit = 1;
  localparam int enc20_bit = 2;

  // status register fields
  localparam int done_bit = 0;
  localparam int tlim_bit = 1;
  localparam int external_input_one_bit = 2;
  localparam int busy_bit = 3;
  localparam int ovf_bit = 4;
  localparam int locked_bit = 5;

  // command codes and trigger types
  localparam logic [7:0] code_normal = 8'h20;
  localparam logic [7:0] code_homing = 8'h24;
  localparam logic [11:0] type_z_rise = 12'h011;
  localparam logic [11:0] type_external_input_one_rise = 12'h018;
  localparam logic [11:0] type_composed_actual_position_set = 12'h021;

  // reset values
  localparam logic [31:0] cmd_rst = 32'h0000_0020;
  localparam logic [31:0] config_rst = 32'h0000_0001;

  // widths of the composed position
  localparam int comp_w = 36;
  localparam int st17_w = 17;
  localparam int st20_w = 20;

  typedef enum logic [1:0] {
    hs_idle = 2'b00,
    hs_seek = 2'b01,
    hs_lock = 2'b10
  } home_state_t;

endpackage

/* servo_homing_asserts.sv */
module servo_homing_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cycle_tick,
  input wire logic [31:0] command_velocity,
  input wire logic homing_done,
  input wire logic homing_busy,
  input wire logic overflow_alarm,
  input wire logic multi_turn_overflow
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RDY: assert property (psel && penable |-> ##[0:9] pready)
    else $error("no pready");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_ERR_ACK: assert property (pslverr |-> psel && penable && pready)
    else $error("error outside access");
  AST_DONE: assert property ($rose(homing_done) |-> $past(homing_busy))
    else $error("early done");
  AST_BUSY_NOT_DONE: assert property (homing_busy |-> !homing_done)
    else $error("done while busy");
  AST_LOCK_ON_DONE: assert property ($rose(homing_done) |-> !homing_busy)
    else $error("busy after done");
  AST_OVF: assert property ($rose(overflow_alarm) |-> $past(multi_turn_overflow))
    else $error("alarm");
  AST_VEL_TICK: assert property ($changed(command_velocity) |-> $past(cycle_tick))
    else $error("velocity off cycle");
endmodule
bind servo_homing servo_homing_asserts servo_homing_asserts_i(.*);

/* host_apb.sv */
module host_apb(input wire logic pclk,output logic psel,output logic penable,
  output logic pwrite,output logic [7:0] paddr,output logic [31:0] pwdata,
  input wire logic [31:0] prdata,input wire logic pready);
  timeunit 1ns; timeprecision 1ps;
  int timeouts=0;
  initial {psel,penable,pwrite,paddr,pwdata}='0;
  task automatic xfer(logic w,logic [7:0] a,logic [31:0] d,output logic [31:0] r);
    int n;
    n=0;
    @(posedge pclk) {psel,pwrite,paddr,pwdata}<={1'b1,w,a,d};
    @(posedge pclk) penable<=1'b1;
    do @(posedge pclk); while(!pready&&++n<99);
    if(!pready) timeouts++;
    r=prdata;
    {psel,penable}<=2'b0;
  endtask
endmodule

/* testbench.sv */
module testbench;
  timeunit 1ns; timeprecision 1ps;
  logic pclk=0,presetn=0,tick=0,z=0,ext=0,tl=0,psel,penable,pwrite,pready,done,busy;
  logic [7:0] paddr; logic [31:0] pwdata,prdata,pos,q,tgt;
  logic [19:0] st=20'h5; logic [15:0] mt=16'hFFFF;
  int miscompares=0,n_tests=0;
  initial forever #2.5 pclk=~pclk;
  always @(posedge pclk) tick<=~tick;
  host_apb h(.*);
  servo_homing servo_homing_i(.*,.pstrb(4'hF),.pslverr(),.cycle_tick(tick),.single_turn(st),
    .multi_turn(mt),.multi_turn_overflow(1'b0),.z_phase(z),.external_input_one(ext),
    .torque_limited(tl),.servo_target(tgt),.command_velocity(),.composed_actual_position(pos),
    .homing_done(done),.homing_busy(busy),.overflow_alarm());
  task automatic chk(string s,logic [31:0] e,logic [31:0] g);
    n_tests++;
    if(g!==e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h",s,e,g);
    end
  endtask
  task automatic t_pos(logic [31:0] c,logic [31:0] e);
    h.xfer(1,servo_homing_pkg::config_off,c,q);
    h.xfer(0,servo_homing_pkg::act_pos_off,0,q);
    chk("composed_actual_position",e,q);
    chk("pos",e,pos);
    $display("pos test end");
  endtask
  task automatic wait_for(logic want_busy);
    for(int n=0;n<999&&(want_busy?busy:done)!==1;n++) @(posedge pclk);
  endtask
  task automatic to_normal;
    h.xfer(1,servo_homing_pkg::cmd_pos_off,0,q);
    h.xfer(1,servo_homing_pkg::cmd_off,32'(servo_homing_pkg::code_normal),q);
    repeat(4) @(posedge pclk);
    chk("busy_off",0,32'(busy));
    chk("done_kept",1,32'(done));
  endtask
  task automatic t_home;
    chk("done0",0,32'(done));
    h.xfer(1,servo_homing_pkg::cmd_off,{4'h0,servo_homing_pkg::type_z_rise,8'h1,
      servo_homing_pkg::code_homing},q);
    wait_for(1);
    chk("busy",1,32'(busy));
    z<=1;
    wait_for(0);
    chk("done",1,32'(done));
    chk("hold",32'h000FFFFB,tgt);
    h.xfer(1,servo_homing_pkg::cmd_off,{4'h0,servo_homing_pkg::type_z_rise,8'h0,
      servo_homing_pkg::code_homing},q);
    z<=0;
    to_normal();
    $display("home test end");
  endtask
  task automatic t_ext;
    h.xfer(1,servo_homing_pkg::cmd_off,{4'h0,servo_homing_pkg::type_external_input_one_rise,8'h0,
      servo_homing_pkg::code_homing},q);
    wait_for(1);
    chk("done_clr",0,32'(done));
    ext<=1;
    repeat(6) @(posedge pclk);
    chk("unarmed",0,32'(done));
    ext<=0;
    repeat(4) @(posedge pclk);
    h.xfer(1,servo_homing_pkg::cmd_off,{4'h0,servo_homing_pkg::type_external_input_one_rise,8'h1,
      servo_homing_pkg::code_homing},q);
    repeat(20) @(posedge pclk);
    ext<=1;
    wait_for(0);
    chk("ext_done",1,32'(done));
    h.xfer(0,servo_homing_pkg::echo_off,0,q);
    chk("echo",32'(servo_homing_pkg::code_homing),q);
    ext<=0;
    to_normal();
    $display("ext test end");
  endtask
  task automatic t_set;
    tl<=1;
    repeat(16) @(posedge pclk);
    h.xfer(0,servo_homing_pkg::status_off,0,q);
    chk("tlim",1,32'(q[servo_homing_pkg::tlim_bit]));
    h.xfer(1,servo_homing_pkg::setting_off,32'h0000_1234,q);
    h.xfer(1,servo_homing_pkg::cmd_off,{4'h0,servo_homing_pkg::type_composed_actual_position_set,8'h0,
      servo_homing_pkg::code_homing},q);
    repeat(8) @(posedge pclk);
    chk("set_done",1,32'(done));
    chk("set_hold",32'h0000_1234,tgt);
    chk("set_pos",32'h0000_1234,pos);
    h.xfer(0,servo_homing_pkg::act_pos_off,0,q);
    chk("set_composed_actual_position",32'h0000_1234,q);
    h.xfer(1,servo_homing_pkg::cmd_pos_off,32'h0000_1234,q);
    h.xfer(1,servo_homing_pkg::cmd_off,32'(servo_homing_pkg::code_normal),q);
    tl<=0;
    repeat(4) @(posedge pclk);
    chk("set_tgt",32'h0000_1234,tgt);
    $display("set test end");
  endtask
  task automatic finish_test;
    miscompares+=h.timeouts;
    $display("compares %0d mismatches %0d",n_tests,miscompares);
    if(miscompares==0&&n_tests>0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat(5) @(posedge pclk);
    presetn<=1;
    t_pos(32'h1,32'hFFFE0005);
    t_pos(32'h0,32'h0001FFFB);
    t_pos(32'h4,32'h000FFFFB);
    t_home();
    t_ext();
    t_set();
    finish_test();
  end
endmodule
